/* pkg/dpflag_pkg.sv */
// constants shared by the dual-port flag controller and its pin sequencer
`default_nettype none

package dpflag_pkg;

  // --------------------------------------------------------------------------
  // clock and pin timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS           = 5;
  localparam int ACCESS_NS               = 25;  // address or enable to data valid
  localparam int WRITE_PULSE_NS          = 20;  // least write strobe width
  localparam int FLAG_REFRESH_PULSE_NS   = 12;  // least fresh select for a flag read
  localparam int RELEASE_TO_DATA_DELAY_NS = 25; // busy high to valid read data
  localparam int SLAVE_WRITE_RELEASE_HOLD_NS = 17; // strobe held after busy high

  // least times round up to whole cycles
  localparam int ACCESS_CYC  = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC   = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC = (FLAG_REFRESH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BDD_CYC     = (RELEASE_TO_DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC    = (SLAVE_WRITE_RELEASE_HOLD_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;

  // strobe lengths, the longest of the figures that apply
  localparam int RD_MAX1 = (ACCESS_CYC > REFRESH_CYC) ? ACCESS_CYC : REFRESH_CYC;
  localparam int RD_CYC  = (RD_MAX1 > BDD_CYC) ? RD_MAX1 : BDD_CYC;
  localparam int WR_CYC  = (PULSE_CYC > HOLD_CYC) ? PULSE_CYC : HOLD_CYC;
  localparam int CNT_W   = 4;
  localparam logic [CNT_W-1:0] READ_CYC  = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] WRITE_CYC = CNT_W'(WR_CYC);

  // --------------------------------------------------------------------------
  // command codes
  // --------------------------------------------------------------------------
  localparam logic [1:0] OP_RAM_READ   = 2'h0;
  localparam logic [1:0] OP_RAM_WRITE  = 2'h1;
  localparam logic [1:0] OP_FLAG_READ  = 2'h2;
  localparam logic [1:0] OP_FLAG_WRITE = 2'h3;
  localparam int OP_WRITE_BIT = 0;
  localparam int OP_FLAG_BIT  = 1;

  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam int         AXI_ADDR_W  = 8;
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_ADDR    = 8'h04;
  localparam logic [7:0] OFS_WDATA   = 8'h08;
  localparam logic [7:0] OFS_RDATA   = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_MASK    = 8'hfc;
  localparam int ST_ACTIVE_BIT  = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_BLOCKED_BIT = 2;
  localparam int ST_REFUSED_BIT = 3;
  localparam int ST_MBOX_BIT    = 4;
  localparam int ST_BUSYN_BIT   = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* logic/port_cycle.sv */
// pin sequencer that runs one access on a dual-port memory port
`default_nettype none

module port_cycle
  import dpflag_pkg::*;
#(
  parameter int ADDR_W = 14
)(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // command side
  input  wire logic              start,
  input  wire logic [1:0]        op,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  output logic                   active,
  output logic                   done,
  output logic                   blocked,
  output logic [7:0]             rdata,
  // memory port pins
  output logic [ADDR_W-1:0]      port_addr,
  output logic                   ce_n,
  output logic                   flag_space_select_n,
  output logic                   rw_n,
  output logic                   oe_n,
  output logic [7:0]             data_out,
  output logic                   data_oe_n,
  input  wire logic [7:0]        data_in,
  input  wire logic              busy_n
);

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_END} state_type;

  state_type        state_reg;
  logic [1:0]       op_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             finish;
  logic             is_write;

  assign is_write = op_reg[OP_WRITE_BIT];
  assign finish   = (state_reg == ST_STROBE) && busy_n && (cnt_reg == CNT_W'(1));
  assign active   = (state_reg != ST_IDLE);

  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  // state and strobe counter; busy low restarts the count so the wait covers
  // both the data delay and the write hold after release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_RAM_READ;
      cnt_reg   <= '0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            op_reg    <= op;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          cnt_reg   <= is_write ? WRITE_CYC : READ_CYC;
          state_reg <= ST_STROBE;
        end
        ST_STROBE:
        begin
          // (R15) hold strobe while busy low
          if (!busy_n)
            cnt_reg <= is_write ? WRITE_CYC : READ_CYC;
          else if (finish)
            state_reg <= ST_END;
          else
            cnt_reg <= cnt_reg - CNT_W'(1);
        end
        ST_END:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // pins
  // --------------------------------------------------------------------------
  // address and data settle a cycle before any strobe falls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_addr           <= '0;
      ce_n                <= 1'b1;
      flag_space_select_n <= 1'b1;
      rw_n                <= 1'b1;
      oe_n                <= 1'b1;
      data_out            <= '0;
      data_oe_n           <= 1'b1;
    end
    else
    begin
      // (R6) address moves only while write strobe is high
      if (state_reg == ST_IDLE && start)
      begin
        port_addr <= addr;
        data_out  <= wdata;
        // (R4) drive data only for writes
        data_oe_n <= !op[OP_WRITE_BIT];
      end
      if (state_reg == ST_SETUP)
      begin
        // (R1) select exactly one space
        ce_n                <= op_reg[OP_FLAG_BIT];
        flag_space_select_n <= !op_reg[OP_FLAG_BIT];
        rw_n                <= !is_write;
        oe_n                <= is_write;
      end
      // (R10) every read gets its own select pulse
      if (finish)
      begin
        ce_n                <= 1'b1;
        flag_space_select_n <= 1'b1;
        rw_n                <= 1'b1;
        oe_n                <= 1'b1;
      end
      if (state_reg == ST_END)
        data_oe_n <= 1'b1;  // zero data hold is enough, one cycle kept anyway
    end
  end

  // results: data captured on the edge the strobes rise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata   <= '0;
      done    <= 1'b0;
      blocked <= 1'b0;
    end
    else
    begin
      done    <= (state_reg == ST_END);
      blocked <= (state_reg == ST_STROBE) && !busy_n;
      if (finish && !is_write)
        rdata <= data_in;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_one_space_only: assert property (@(posedge aclk) disable iff (!aresetn) // (R4)
    !(!ce_n && !flag_space_select_n))
    else $error("both spaces selected at once");

  a_addr_write_safe: assert property (@(posedge aclk) disable iff (!aresetn) // (R6)
    !$stable(port_addr) |-> rw_n && $past(rw_n))
    else $error("address changed with write strobe low");

  a_read_no_drive: assert property (@(posedge aclk) disable iff (!aresetn) // (R4)
    !data_oe_n |-> oe_n && $past(oe_n))
    else $error("data driven while output enable low");

  a_flag_pulse_width: assert property (@(posedge aclk) disable iff (!aresetn) // (R10)
    $fell(flag_space_select_n) |-> !flag_space_select_n [*3])
    else $error("flag select pulse too short");

  a_slave_write_hold: assert property (@(posedge aclk) disable iff (!aresetn) // (R15)
    $rose(busy_n) && !rw_n && !ce_n |-> !rw_n [*4])
    else $error("write ended too soon after busy release");

  a_strobe_with_select: assert property (@(posedge aclk) disable iff (!aresetn) // (R1)
    $fell(rw_n) |-> ($fell(ce_n) ^ $fell(flag_space_select_n)) ##1 !data_oe_n)
    else $error("write strobe without one space select");

endmodule // port_cycle

`default_nettype wire

/* logic/dpflag_ctrl.sv */
// host controller for one port of a dual-port memory with semaphore flags
//
// Operation
// (R1) enable low with select high is memory; enable high, select low is flags.
// (R2) device drives flag state on reads of flag space with output enable low.
// (R3) device updates addressed flag on writes into flag space.
// (R4) never both selects low; data floats unless writing with output enable high.
// (R5) a write happens only while write strobe and a select overlap low.
// (R6) address lines change only while the write strobe is high.
// (R7) select falling with or after write strobe keeps device outputs floating.
// (R8) flags start released and free for both ports.
// (R9) simultaneous flag requests: exactly one port wins, unpredictably.
// (R10) each flag read needs a fresh select pulse of at least 12 ns.
// (R11) writing 0 takes a free flag; holder writing 1 passes or frees it.
// (R12) matching addresses drive busy low to the loser until they differ.
// (R13) enable falling onto a match asserts busy; it clears after enable rises.
// (R14) accesses closer than the priority window still block exactly one side.
// (R15) in slave mode no write ends while busy low; hold 17 ns after.
// (R16) a read blocked by busy yields data within 25 ns of release.
// (R17) left write to top address drives the right mailbox flag low.
// (R18) right read of top address releases the right mailbox flag.
// (R19) right write one below top drives the left mailbox flag low.
// (R20) left read one below top releases the left mailbox flag.
// (R21) a mailbox access blocked by busy leaves the flag unchanged.
// (R22) mailbox locations still store ordinary data bytes.
`default_nettype none

module dpflag_ctrl
  import dpflag_pkg::*;
#(
  parameter int ADDR_W = 14
)(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address and data
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  // axi4-lite write response
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // axi4-lite read
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // memory port pins
  output logic [ADDR_W-1:0]          port_addr,
  output logic                       ce_n,
  output logic                       flag_space_select_n,
  output logic                       rw_n,
  output logic                       oe_n,
  output logic [7:0]                 data_out,
  output logic                       data_oe_n,
  input  wire logic [7:0]            data_in,
  input  wire logic                  busy_n,
  input  wire logic                  mailbox_int_n
);

  // the sequencer addresses 8k or 16k parts only
  if (ADDR_W < 13 || ADDR_W > 14)
  begin : g_bad_width
    $error("ADDR_W must be 13 or 14");
  end

  logic [AXI_ADDR_W-1:0] awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  aw_hold_reg;
  logic                  w_hold_reg;
  logic                  do_write;
  logic [7:0]            wofs;
  logic [7:0]            rofs;
  logic [1:0]            op_reg;
  logic [ADDR_W-1:0]     addr_reg;
  logic [7:0]            wbyte_reg;
  logic                  start_reg;
  logic                  done_reg;
  logic                  blocked_reg;
  logic                  refused_reg;
  logic                  seq_active;
  logic                  seq_done;
  logic                  seq_blocked;
  logic [7:0]            seq_rdata;
  logic                  cmd_write;
  logic                  status_write;
  logic                  wmapped;
  logic                  rmapped;
  logic [31:0]           rmux;

  assign do_write     = aw_hold_reg && w_hold_reg && !bvalid;
  assign wofs         = awaddr_reg & OFS_MASK;
  assign rofs         = araddr & OFS_MASK;
  assign cmd_write    = do_write && (wofs == OFS_CMD) && wstrb_reg[0];
  assign status_write = do_write && (wofs == OFS_STATUS) && wstrb_reg[0];
  assign wmapped      = (wofs == OFS_CMD) || (wofs == OFS_ADDR) || (wofs == OFS_WDATA)
                        || (wofs == OFS_RDATA) || (wofs == OFS_STATUS);
  assign rmapped      = (rofs == OFS_CMD) || (rofs == OFS_ADDR) || (rofs == OFS_WDATA)
                        || (rofs == OFS_RDATA) || (rofs == OFS_STATUS);

  // --------------------------------------------------------------------------
  // write channels
  // --------------------------------------------------------------------------
  // address and data are caught in either order; ready stays low until the
  // response is taken, so one write at a time is under way
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      awaddr_reg  <= '0;
      awready     <= 1'b0;
    end
    else if (awvalid && awready)
    begin
      aw_hold_reg <= 1'b1;
      awaddr_reg  <= awaddr;
      awready     <= 1'b0;
    end
    else
    begin
      if (do_write)
        aw_hold_reg <= 1'b0;
      if (!aw_hold_reg && !bvalid && !do_write)
        awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
      wready     <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      w_hold_reg <= 1'b1;
      wdata_reg  <= wdata;
      wstrb_reg  <= wstrb;
      wready     <= 1'b0;
    end
    else
    begin
      if (do_write)
        w_hold_reg <= 1'b0;
      if (!w_hold_reg && !bvalid && !do_write)
        wready <= 1'b1;
    end
  end

  // response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= wmapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  // command parameters; byte lanes honoured per field
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_reg    <= OP_RAM_READ;
      addr_reg  <= '0;
      wbyte_reg <= '0;
    end
    else if (do_write)
    begin
      if (cmd_write && !seq_active && !start_reg)
        op_reg <= wdata_reg[1:0];
      if (wofs == OFS_ADDR)
      begin
        if (wstrb_reg[0])
          addr_reg[7:0] <= wdata_reg[7:0];
        if (wstrb_reg[1])
          addr_reg[ADDR_W-1:8] <= wdata_reg[ADDR_W-1:8];
      end
      if (wofs == OFS_WDATA && wstrb_reg[0])
        wbyte_reg <= wdata_reg[7:0];
    end
  end

  // a command written while an access runs is dropped, not queued
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start_reg <= 1'b0;
    else
      start_reg <= cmd_write && !seq_active && !start_reg;
  end

  // sticky status; a new event in the clearing cycle survives the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_reg    <= 1'b0;
      blocked_reg <= 1'b0;
      refused_reg <= 1'b0;
    end
    else
    begin
      done_reg    <= seq_done
                     || (done_reg && !(status_write && wdata_reg[ST_DONE_BIT]));
      blocked_reg <= seq_blocked
                     || (blocked_reg && !(status_write && wdata_reg[ST_BLOCKED_BIT]));
      refused_reg <= (cmd_write && (seq_active || start_reg))
                     || (refused_reg && !(status_write && wdata_reg[ST_REFUSED_BIT]));
    end
  end

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  // read data mux; the mailbox pin is shown inverted, the busy pin as a plain level
  always_comb
  begin
    rmux = '0;
    unique case (rofs)
      OFS_CMD:    rmux[1:0] = op_reg;
      OFS_ADDR:   rmux[ADDR_W-1:0] = addr_reg;
      OFS_WDATA:  rmux[7:0] = wbyte_reg;
      OFS_RDATA:  rmux[7:0] = seq_rdata;
      OFS_STATUS:
      begin
        rmux[ST_ACTIVE_BIT]  = seq_active || start_reg;
        rmux[ST_DONE_BIT]    = done_reg;
        rmux[ST_BLOCKED_BIT] = blocked_reg;
        rmux[ST_REFUSED_BIT] = refused_reg;
        rmux[ST_MBOX_BIT]    = !mailbox_int_n;
        rmux[ST_BUSYN_BIT]   = busy_n;
      end
      default:    rmux = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rmux;
      rresp   <= rmapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end

  // --------------------------------------------------------------------------
  // pin sequencer
  // --------------------------------------------------------------------------
  port_cycle #(
    .ADDR_W (ADDR_W)
  ) u_cycle (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .start               (start_reg),
    .op                  (op_reg),
    .addr                (addr_reg),
    .wdata               (wbyte_reg),
    .active              (seq_active),
    .done                (seq_done),
    .blocked             (seq_blocked),
    .rdata               (seq_rdata),
    .port_addr           (port_addr),
    .ce_n                (ce_n),
    .flag_space_select_n (flag_space_select_n),
    .rw_n                (rw_n),
    .oe_n                (oe_n),
    .data_out            (data_out),
    .data_oe_n           (data_oe_n),
    .data_in             (data_in),
    .busy_n              (busy_n)
  );

endmodule // dpflag_ctrl

`default_nettype wire

/* dv/dpflag_dev_model.sv */
// behavioural model of one port of a dual-port memory with flags
`default_nettype none

module dpflag_dev_model
  import dpflag_pkg::*;
#(
  parameter int ADDR_W = 14
)(
  // clock for sampling
  input  wire logic              aclk,
  // memory port pins
  input  wire logic [ADDR_W-1:0] port_addr,
  input  wire logic              ce_n,
  input  wire logic              flag_space_select_n,
  input  wire logic              rw_n,
  input  wire logic              oe_n,
  input  wire logic [7:0]        data_out,
  input  wire logic              data_oe_n,
  output logic [7:0]             data_in,
  output logic                   busy_n,
  output logic                   mailbox_int_n,
  // far port stand-ins
  input  wire logic [3:0]        busy_len,
  input  wire logic [7:0]        other_owns,
  input  wire logic              mbox_set
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mine = 8'h00;
  logic [7:0] mem [0:(2**ADDR_W)-1];
  logic [3:0] bcnt = 4'h0;
  logic       ce_q = 1'b1;
  logic       mbox_reg = 1'b1;
  logic [7:0] rd_val;
  logic       ram_sel;
  logic       flag_sel;
  logic       drive;
  assign ram_sel  = !ce_n && flag_space_select_n;
  assign flag_sel = ce_n && !flag_space_select_n;
  // drive only reads, never under strobe or busy
  assign drive  = (ram_sel || flag_sel) && rw_n && !oe_n && busy_n;
  assign rd_val = ram_sel ? mem[port_addr] : {8{!mine[port_addr[2:0]]}};
  // a released bus shows the inverse so a stale sample cannot pass
  assign data_in = !data_oe_n ? data_out : (drive ? rd_val : ~rd_val);
  assign busy_n  = (bcnt == 4'h0);
  assign mailbox_int_n = mbox_reg;
  // busy after enable falls onto a contended address
  always @(posedge aclk)
  begin
    ce_q <= ce_n;
    if (ce_q && !ce_n && busy_len != 4'h0) bcnt <= busy_len;
    else if (bcnt != 4'h0) bcnt <= bcnt - 4'h1;
  end
  // write only while strobe and select overlap
  always @(posedge aclk)
    if (!rw_n && ram_sel && busy_n) mem[port_addr] <= data_out;
  // take on zero unless the far port holds it, free on one
  always @(posedge aclk)
    if (!rw_n && flag_sel)
      mine[port_addr[2:0]] <= !data_out[0] && !other_owns[port_addr[2:0]];
  // mailbox flag, cleared only by an unblocked read
  always @(posedge aclk)
    if (mbox_set) mbox_reg <= 1'b0;
    else if (drive && ram_sel && port_addr == ~ADDR_W'(1)) mbox_reg <= 1'b1;
endmodule // dpflag_dev_model

`default_nettype wire

/* dv/dual_port_arbitration_flags_tb_top.sv */
// register-level testbench for the dual-port flag controller
`default_nettype none

module dual_port_arbitration_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dpflag_pkg::*;
  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  localparam int AW = 14;
  logic aclk = 1'b0, aresetn = 1'b0, mbox_set = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, other_owns = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0, busy_len = 4'h0, hold = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, ce_n, flag_space_select_n;
  logic rw_n, oe_n, data_oe_n, busy_n, mailbox_int_n;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, st, rd;
  logic [AW-1:0] port_addr, prev_addr;
  logic [7:0] data_out, data_in;
  logic pin_viol = 1'b0, prev_rw = 1'b1, busy_seen = 1'b0;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  logic [13:0] ta [3] = '{14'h0123, 14'h3ffe, 14'h3fff};
  logic [7:0] td [3] = '{8'h5a, 8'h3c, 8'ha5};

  dpflag_ctrl #(.ADDR_W(AW)) u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .port_addr, .ce_n, .flag_space_select_n,
    .rw_n, .oe_n, .data_out, .data_oe_n, .data_in, .busy_n, .mailbox_int_n);
  dpflag_dev_model #(.ADDR_W(AW)) u_dev (.aclk, .port_addr, .ce_n, .flag_space_select_n,
    .rw_n, .oe_n, .data_out, .data_oe_n, .data_in, .busy_n, .mailbox_int_n,
    .busy_len, .other_owns, .mbox_set);

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // poll done under a bound, keep the status seen, then clear sticky bits
  task automatic wait_done;
    logic [1:0] r;
    int i;
    st = 32'h0;
    for (i = 0; i < 40 && st[ST_DONE_BIT] !== 1'b1; i++) rdr(OFS_STATUS, st, r);
    cmp(st & 32'h2, 32'h2);
    wr(OFS_STATUS, 32'he, r);
  endtask
  task automatic run(input logic [1:0] op, input logic [13:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(OFS_ADDR, 32'(a), r);
    wr(OFS_WDATA, 32'(d), r);
    wr(OFS_CMD, 32'(op), r);
    wait_done();
  endtask
  task automatic chk(input logic [1:0] op, input logic [13:0] a, input logic [31:0] exp);
    run(op, a, 8'h00);
    rdr(OFS_RDATA, rd, rsp);
    cmp(rd, exp);
  endtask
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // monitors
  // --------------------------------------------------------------------------
  // pin watch: both spaces, two drivers, address under strobe, slave hold of 4 cycles
  always @(posedge aclk)
  begin
    prev_rw <= rw_n;
    prev_addr <= port_addr;
    if (aresetn && ((!ce_n && !flag_space_select_n) || (!data_oe_n && !oe_n))) pin_viol <= 1'b1;
    if (!rw_n && !prev_rw && port_addr != prev_addr) pin_viol <= 1'b1;
    if (rw_n) begin busy_seen <= 1'b0; hold <= 4'h0; end
    else if (!busy_n) begin busy_seen <= 1'b1; hold <= 4'h0; end
    else if (hold != 4'hf) hold <= hold + 4'h1;
    if (rw_n && !prev_rw && busy_seen && hold < HOLD_CYC) pin_viol <= 1'b1;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin n_mismatch++; summarize(); end
  end

  // --------------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdr(OFS_STATUS, rd, rsp);
    cmp(rd, 32'h20);
    for (int k = 0; k < 3; k++) run(OP_RAM_WRITE, ta[k], td[k]);
    for (int k = 0; k < 3; k++) chk(OP_RAM_READ, ta[k], 32'(td[k]));
    busy_len <= 4'h3;
    run(OP_RAM_WRITE, 14'h0040, 8'h77);
    chk(OP_RAM_READ, 14'h0040, 32'h77);
    cmp(st & 32'h4, 32'h4);
    busy_len <= 4'h0;
    chk(OP_FLAG_READ, 14'h0002, 32'hff);
    run(OP_FLAG_WRITE, 14'h0002, 8'h00);
    chk(OP_FLAG_READ, 14'h0002, 32'h00);
    other_owns <= 8'h20;
    run(OP_FLAG_WRITE, 14'h0005, 8'h00);
    chk(OP_FLAG_READ, 14'h0005, 32'hff);
    run(OP_FLAG_WRITE, 14'h0002, 8'h01);
    chk(OP_FLAG_READ, 14'h0002, 32'hff);
    @(posedge aclk) mbox_set <= 1'b1;
    @(posedge aclk) mbox_set <= 1'b0;
    rdr(OFS_STATUS, rd, rsp);
    cmp(rd & 32'h10, 32'h10);
    chk(OP_RAM_READ, 14'h3ffe, 32'h3c);
    rdr(OFS_STATUS, rd, rsp);
    cmp(rd & 32'h10, 32'h0);
    // second command lands while the first is stretched by busy
    busy_len <= 4'h6;
    wr(OFS_CMD, 32'(OP_RAM_READ), rsp);
    wr(OFS_CMD, 32'(OP_RAM_WRITE), rsp);
    wait_done();
    cmp(st & 32'h8, 32'h8);
    rdr(OFS_RDATA, rd, rsp);
    cmp(rd, 32'h3c);
    busy_len <= 4'h0;
    wr(8'h40, 32'h1, rsp);
    cmp(32'(rsp), 32'(RESP_SLVERR));
    rdr(8'h40, rd, rsp);
    cmp(rd, 32'h0);
    cmp(32'(rsp), 32'(RESP_SLVERR));
    cmp(32'(pin_viol), 32'h0);
    summarize();
  end
endmodule // dual_port_arbitration_flags_tb_top

`default_nettype wire
